// [hw/rts_cfg.svh]
`ifndef RTS_CFG_SVH
`define RTS_CFG_SVH
`define RTS_CLK_PERIOD_NS 4
`define RTS_SETTLE_UNIT_NS 1000
`define RTS_SETTLE_UNIT_CYC (`RTS_SETTLE_UNIT_NS / `RTS_CLK_PERIOD_NS)
`define RTS_SCL_PERIOD_NS 400
`define RTS_SCL_QTR_CYC (`RTS_SCL_PERIOD_NS / (4 * `RTS_CLK_PERIOD_NS))
`define RTS_DEV_ADDR 7'h48
`define RTS_SYNC_RST 2'h3
`define RTS_BITS_BYTE 4'h8
`define RTS_BIT_LAST 4'h7
`define RTS_REG_CFG 3'h4
`define RTS_REG_STAT 3'h5
`define RTS_REG_LAST 3'h5
`define RTS_CFG_RST 16'h0000
`define RTS_CFG_MODE 1:0
`define RTS_CFG_PINPEN 2
`define RTS_CFG_ZLOW 3
`define RTS_CFG_SETTLE 15:8
`define RTS_STAT_RDY 15
`define RTS_STAT_TOUCH 14
`define RTS_CB_CMD 7
`define RTS_CB_FN 6:4
`define RTS_CB_SWRST 3
`define RTS_CB_REG 5:3
`define RTS_CB_RD 0
`define RTS_LOWRES_SHIFT 2
`define RTS_HA_CMD 8'h00
`define RTS_HA_TXD 8'h04
`define RTS_HA_STAT 8'h08
`define RTS_HA_IRQ_ST 8'h0C
`define RTS_HA_IRQ_EN 8'h10
`define RTS_HA_IRQ_CLR 8'h14
`define RTS_OP_START 0
`define RTS_OP_STOP 1
`define RTS_OP_WR 2
`define RTS_OP_RD 3
`define RTS_OP_NACK 4
`define RTS_ST_BUSY 8
`define RTS_ST_NACK 9
`define RTS_ST_PIN 10
`define RTS_EV_DONE 0
`define RTS_EV_PIN 1
`endif

// [hw/rts_pkg.sv]
package rts_pkg;
	typedef enum logic [2:0] {RTS_FN_SCAN, RTS_FN_DRV_X, RTS_FN_DRV_Y, RTS_FN_DRV_Z,
		RTS_FN_CONV_X, RTS_FN_CONV_Y, RTS_FN_CONV_Z1, RTS_FN_CONV_Z2} rts_fn_e;
	typedef enum logic [1:0] {RTS_MODE_SELF, RTS_MODE_TOUCH, RTS_MODE_HOST, RTS_MODE_RSVD} rts_mode_e;
	typedef enum logic [1:0] {RTS_CH_X, RTS_CH_Y, RTS_CH_Z1, RTS_CH_Z2} rts_ch_e;
	typedef enum {RTS_SQ_IDLE, RTS_SQ_SETTLE, RTS_SQ_CONV, RTS_SQ_WAIT} rts_sq_e;
	typedef enum {RTS_I2_IDLE, RTS_I2_ADDR, RTS_I2_AACK, RTS_I2_RX, RTS_I2_RACK, RTS_I2_TX,
		RTS_I2_MACK} rts_i2_e;
	typedef enum {RTS_H_IDLE, RTS_H_START, RTS_H_BIT, RTS_H_STOP} rts_hs_e;
endpackage

// [hw/rts_if.sv]
`timescale 1ns/10ps
interface rts_if;
	logic scl;
	logic sda;
	logic sda_do_h;
	logic sda_oe_h;
	logic sda_do_d;
	logic sda_oe_d;
	logic shared_irq_status_pin;
	// open-drain wire with pull-up
	assign sda = !((sda_oe_h && !sda_do_h) || (sda_oe_d && !sda_do_d));
	modport dev (input scl, input sda, output sda_do_d, output sda_oe_d,
		output shared_irq_status_pin);
	modport host (output scl, input sda, output sda_do_h, output sda_oe_h,
		input shared_irq_status_pin);
endinterface

// [hw/rts_dev.sv]
`timescale 1ns/10ps
`include "rts_cfg.svh"
////////////////////////////////////////////////////////////////////////////////
// Contract
// - device is serial slave, host clocks everything
// - control bytes or control plus data pairs
// - read addressing returns sequential register words
// - control byte with read bit sets pointer
// - pointer kept until rewritten or reset
// - results readable anytime without handshake
// - pin in ready mode shows conversion done
// - pin in pen mode shows touch
// - status register shows ready and touch
// - Y: drive Y plates, sense X+
// - X: drive X plates, sense Y
// - two cross readings scaled to 12 bits
// - X, Y, each cross reading separately readable
// - host prefers low resolution for pressure
// - settle programmable time before conversion, skipped for single conversions in host mode
// - drive-only command, later separate conversion
// - three conversion control modes
// - idle: Y- grounded, touch via X+
module rts_dev import rts_pkg::*; #(
	parameter int SETTLE_UNIT_CYC = `RTS_SETTLE_UNIT_CYC,
	parameter logic [6:0] DEV_ADDR = `RTS_DEV_ADDR
) (
	input wire logic hclk,
	input wire logic hresetn,
	rts_if.dev lnk,
	input wire logic pen_touch_n,
	output logic drv_xp,
	output logic drv_xn,
	output logic drv_yp,
	output logic drv_yn,
	output logic pen_pullup_en,
	output logic adc_start,
	output logic [1:0] adc_chan,
	output logic adc_lowres,
	input wire logic adc_done,
	input wire logic [11:0] adc_data,
	output logic result_ready_flag,
	output logic touch_detect_irq
);
	logic [1:0] scl_y_q, sda_y_q, pen_y_q;
	logic scl_p_q, sda_p_q;
	logic scl_s, sda_s, start_c, stop_c, rise_c, fall_c;
	rts_i2_e i2_q;
	logic [3:0] bit_q;
	logic [7:0] sh_q, tx_q, nxt_byte;
	logic rnw_q, oe_q, rd_lo_q, byte_v_q, awr_q, ard_q;
	logic [2:0] rd_idx_q, ptr_q, wreg_q;
	logic [1:0] wcnt_q;
	logic [7:0] whi_q;
	logic [15:0] cfg_q, rd_word;
	logic [15:0] res_q [4];
	logic cmd_v_q, swrst_q, rdy_q, rdy_set_q, touch_q, drv_on_q, active;
	rts_fn_e cmd_fn_q;
	rts_sq_e sq_q;
	rts_ch_e ch_q, last_q;
	rts_mode_e mode;
	logic [31:0] cnt_q, settle_len;
	logic [11:0] scaled;

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			scl_y_q <= `RTS_SYNC_RST;
			sda_y_q <= `RTS_SYNC_RST;
			pen_y_q <= `RTS_SYNC_RST;
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_y_q <= {scl_y_q[0], lnk.scl};
			sda_y_q <= {sda_y_q[0], lnk.sda};
			pen_y_q <= {pen_y_q[0], pen_touch_n};
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
		end
	end
	assign scl_s = scl_y_q[1];
	assign sda_s = sda_y_q[1];
	assign start_c = scl_s && scl_p_q && sda_p_q && !sda_s;
	assign stop_c = scl_s && scl_p_q && !sda_p_q && sda_s;
	assign rise_c = scl_s && !scl_p_q;
	assign fall_c = !scl_s && scl_p_q;

	////////////////////////////////////////////////////////////////////////////
	// register map as seen by reads
	always_comb begin
		rd_word = 16'h0000;
		if (rd_idx_q < `RTS_REG_CFG)
			rd_word = res_q[rd_idx_q[1:0]];
		else if (rd_idx_q == `RTS_REG_CFG)
			rd_word = cfg_q;
		else if (rd_idx_q == `RTS_REG_STAT) begin
			rd_word[`RTS_STAT_RDY] = rdy_q;
			rd_word[`RTS_STAT_TOUCH] = touch_q;
		end
	end
	assign nxt_byte = rd_lo_q ? rd_word[7:0] : rd_word[15:8];

	// serial slave: samples on SCL rise, changes SDA after SCL fall
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			i2_q <= RTS_I2_IDLE;
			bit_q <= 4'h0;
			sh_q <= 8'h00;
			tx_q <= 8'h00;
			rnw_q <= 1'b0;
			oe_q <= 1'b0;
			rd_idx_q <= 3'h0;
			rd_lo_q <= 1'b0;
			byte_v_q <= 1'b0;
			awr_q <= 1'b0;
			ard_q <= 1'b0;
		end else begin
			byte_v_q <= 1'b0;
			awr_q <= 1'b0;
			ard_q <= 1'b0;
			if (start_c) begin
				i2_q <= RTS_I2_ADDR;
				bit_q <= 4'h0;
				oe_q <= 1'b0;
			end else if (stop_c) begin
				i2_q <= RTS_I2_IDLE;
				oe_q <= 1'b0;
			end else begin
				unique case (i2_q)
				RTS_I2_IDLE: begin
				end
				RTS_I2_ADDR, RTS_I2_RX: begin
					if (rise_c) begin
						sh_q <= {sh_q[6:0], sda_s};
						bit_q <= bit_q + 4'h1;
					end else if (fall_c && bit_q == `RTS_BITS_BYTE) begin
						if (i2_q == RTS_I2_RX) begin
							i2_q <= RTS_I2_RACK;
							oe_q <= 1'b1;
							byte_v_q <= 1'b1;
						end else if (sh_q[7:1] == DEV_ADDR) begin
							i2_q <= RTS_I2_AACK;
							oe_q <= 1'b1;
							rnw_q <= sh_q[0];
							awr_q <= !sh_q[0];
							ard_q <= sh_q[0];
							rd_idx_q <= ptr_q;
							rd_lo_q <= 1'b0;
						end else begin
							i2_q <= RTS_I2_IDLE;
						end
					end
				end
				RTS_I2_RACK: begin
					if (fall_c) begin
						i2_q <= RTS_I2_RX;
						bit_q <= 4'h0;
						oe_q <= 1'b0;
					end
				end
				RTS_I2_TX: begin
					if (fall_c) begin
						if (bit_q == `RTS_BIT_LAST) begin
							i2_q <= RTS_I2_MACK;
							oe_q <= 1'b0;
						end else begin
							bit_q <= bit_q + 4'h1;
							tx_q <= {tx_q[6:0], 1'b0};
							oe_q <= !tx_q[6];
						end
					end
				end
				RTS_I2_AACK, RTS_I2_MACK: begin
					if (rise_c && i2_q == RTS_I2_MACK && sda_s) begin
						i2_q <= RTS_I2_IDLE; // master ended the read
					end else if (fall_c && (rnw_q || i2_q == RTS_I2_MACK)) begin
						i2_q <= RTS_I2_TX;
						tx_q <= nxt_byte;
						oe_q <= !nxt_byte[7];
						bit_q <= 4'h0;
						rd_lo_q <= !rd_lo_q;
						if (rd_lo_q)
							rd_idx_q <= (rd_idx_q == `RTS_REG_LAST) ? 3'h0 : rd_idx_q + 3'h1;
					end else if (fall_c) begin
						i2_q <= RTS_I2_RX;
						bit_q <= 4'h0;
						oe_q <= 1'b0;
					end
				end
				endcase
			end
		end
	end
	assign lnk.sda_do_d = 1'b0;
	assign lnk.sda_oe_d = oe_q;

	////////////////////////////////////////////////////////////////////////////
	// byte protocol: control byte, then optional data pair
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_q <= `RTS_CFG_RST;
			ptr_q <= 3'h0;
			wcnt_q <= 2'h0;
			wreg_q <= 3'h0;
			whi_q <= 8'h00;
			cmd_v_q <= 1'b0;
			cmd_fn_q <= RTS_FN_SCAN;
			swrst_q <= 1'b0;
		end else begin
			cmd_v_q <= 1'b0;
			swrst_q <= 1'b0;
			if (awr_q) begin
				wcnt_q <= 2'h0;
			end else if (byte_v_q) begin
				unique case (wcnt_q)
				2'h0: begin
					if (sh_q[`RTS_CB_CMD] && sh_q[`RTS_CB_SWRST]) begin
						swrst_q <= 1'b1;
						cfg_q <= `RTS_CFG_RST;
						ptr_q <= 3'h0;
					end else if (sh_q[`RTS_CB_CMD]) begin
						cmd_v_q <= 1'b1;
						cmd_fn_q <= rts_fn_e'(sh_q[`RTS_CB_FN]);
					end else if (sh_q[`RTS_CB_RD]) begin
						ptr_q <= sh_q[`RTS_CB_REG];
					end else begin
						wreg_q <= sh_q[`RTS_CB_REG];
						wcnt_q <= 2'h1;
					end
				end
				2'h1: begin
					whi_q <= sh_q;
					wcnt_q <= 2'h2;
				end
				2'h2: begin
					if (wreg_q == `RTS_REG_CFG)
						cfg_q <= {whi_q, sh_q};
					wcnt_q <= 2'h0;
				end
				default: wcnt_q <= 2'h0;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	assign mode = rts_mode_e'(cfg_q[`RTS_CFG_MODE]);
	assign settle_len = 32'(cfg_q[`RTS_CFG_SETTLE]) * 32'(SETTLE_UNIT_CYC);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sq_q <= RTS_SQ_IDLE;
			ch_q <= RTS_CH_X;
			last_q <= RTS_CH_X;
			drv_on_q <= 1'b0;
			cnt_q <= 32'h0;
			rdy_set_q <= 1'b0;
		end else if (swrst_q) begin
			sq_q <= RTS_SQ_IDLE;
			drv_on_q <= 1'b0;
			rdy_set_q <= 1'b0;
		end else begin
			rdy_set_q <= 1'b0;
			cnt_q <= 32'h0;
			unique case (sq_q)
			RTS_SQ_IDLE: begin
				if (cmd_v_q && cmd_fn_q inside {RTS_FN_DRV_X, RTS_FN_DRV_Y, RTS_FN_DRV_Z}) begin
					drv_on_q <= 1'b1;
					ch_q <= rts_ch_e'(cmd_fn_q[1:0] - 2'h1);
				end else if (cmd_v_q && cmd_fn_q[2]) begin
					ch_q <= rts_ch_e'(cmd_fn_q[1:0]);
					last_q <= rts_ch_e'(cmd_fn_q[1:0]);
					drv_on_q <= 1'b1;
					// host-driven: drivers were settled by the host's own wait
					sq_q <= (mode == RTS_MODE_HOST) ? RTS_SQ_CONV : RTS_SQ_SETTLE;
				end else if ((cmd_v_q && cmd_fn_q == RTS_FN_SCAN) ||
					(mode == RTS_MODE_SELF && touch_q && !drv_on_q)) begin
					ch_q <= RTS_CH_X;
					last_q <= RTS_CH_Z2;
					drv_on_q <= 1'b1;
					sq_q <= RTS_SQ_SETTLE;
				end
			end
			RTS_SQ_SETTLE: begin
				if (cnt_q >= settle_len)
					sq_q <= RTS_SQ_CONV;
				else
					cnt_q <= cnt_q + 32'h1;
			end
			RTS_SQ_CONV: sq_q <= RTS_SQ_WAIT;
			RTS_SQ_WAIT: begin
				if (adc_done && ch_q == last_q) begin
					sq_q <= RTS_SQ_IDLE;
					drv_on_q <= 1'b0;
					rdy_set_q <= 1'b1;
				end else if (adc_done) begin
					ch_q <= rts_ch_e'(ch_q + 2'h1);
					sq_q <= RTS_SQ_SETTLE;
				end
			end
			endcase
		end
	end

	// low-resolution codes sit in the low bits; shift up to 12-bit scale
	assign scaled = adc_lowres ? (adc_data << `RTS_LOWRES_SHIFT) : adc_data;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < 4; i++)
				res_q[i] <= 16'h0000;
		end else if (swrst_q) begin
			for (int i = 0; i < 4; i++)
				res_q[i] <= 16'h0000;
		end else if (sq_q == RTS_SQ_WAIT && adc_done) begin
			res_q[ch_q] <= {4'h0, scaled};
		end
	end

	// set wins over the clear taken by a read addressing
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdy_q <= 1'b0;
			touch_q <= 1'b0;
		end else begin
			touch_q <= !active && !pen_y_q[1];
			if (swrst_q)
				rdy_q <= 1'b0;
			else if (rdy_set_q)
				rdy_q <= 1'b1;
			else if (ard_q)
				rdy_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	assign active = drv_on_q || sq_q != RTS_SQ_IDLE;
	assign drv_xp = active && ch_q == RTS_CH_X;
	assign drv_xn = active && ch_q != RTS_CH_Y;
	assign drv_yp = active && ch_q != RTS_CH_X;
	assign drv_yn = active ? ch_q == RTS_CH_Y : 1'b1;
	assign pen_pullup_en = !active;
	assign adc_start = sq_q == RTS_SQ_CONV;
	assign adc_chan = ch_q;
	assign adc_lowres = cfg_q[`RTS_CFG_ZLOW] && (ch_q == RTS_CH_Z1 || ch_q == RTS_CH_Z2);
	assign result_ready_flag = rdy_q;
	assign touch_detect_irq = touch_q;
	assign lnk.shared_irq_status_pin = cfg_q[`RTS_CFG_PINPEN] ? touch_q : rdy_q;
endmodule // rts_dev

// [hw/rts_host.sv]
`timescale 1ns/10ps
`include "rts_cfg.svh"
module rts_host import rts_pkg::*; #(
	parameter int SCL_QTR_CYC = `RTS_SCL_QTR_CYC
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	output logic irq,
	rts_if.host lnk
);
	logic a_wr_q;
	logic [7:0] a_addr_q, txd_q, rxd_q, sh_q;
	logic [31:0] hrdata_q, stat;
	logic op_stop_q, op_wr_q, op_nack_q, nack_q, scl_q, oe_q, done_q;
	logic [1:0] sda_y_q, pin_y_q, ist_q, ien_q, ev;
	logic pin_p_q;
	logic [15:0] div_q;
	logic qt;
	logic [1:0] ph_q;
	logic [3:0] bit_q;
	rts_hs_e hs_q;

	////////////////////////////////////////////////////////////////////////////
	// zero-wait slave; read data registered in the address phase
	assign stat = {21'h0, pin_y_q[1], nack_q, hs_q != RTS_H_IDLE, rxd_q};
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			a_wr_q <= 1'b0;
			a_addr_q <= 8'h00;
			hrdata_q <= 32'h0;
		end else begin
			a_wr_q <= hsel && hready && htrans[1] && hwrite;
			if (hsel && hready && htrans[1]) begin
				a_addr_q <= haddr[7:0];
				unique case (haddr[7:0])
				`RTS_HA_TXD: hrdata_q <= {24'h0, txd_q};
				`RTS_HA_STAT: hrdata_q <= stat;
				`RTS_HA_IRQ_ST: hrdata_q <= {30'h0, ist_q};
				`RTS_HA_IRQ_EN: hrdata_q <= {30'h0, ien_q};
				default: hrdata_q <= 32'h0;
				endcase
			end
		end
	end
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_q;

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sda_y_q <= `RTS_SYNC_RST;
			pin_y_q <= 2'h0;
			pin_p_q <= 1'b0;
		end else begin
			sda_y_q <= {sda_y_q[0], lnk.sda};
			pin_y_q <= {pin_y_q[0], lnk.shared_irq_status_pin};
			pin_p_q <= pin_y_q[1];
		end
	end

	// quarter-bit tick; the host alone makes SCL
	assign qt = div_q == 16'(SCL_QTR_CYC - 1);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			div_q <= 16'h0;
		else if (hs_q == RTS_H_IDLE || qt)
			div_q <= 16'h0;
		else
			div_q <= div_q + 16'h1;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hs_q <= RTS_H_IDLE;
			txd_q <= 8'h00;
			rxd_q <= 8'h00;
			sh_q <= 8'h00;
			op_stop_q <= 1'b0;
			op_wr_q <= 1'b0;
			op_nack_q <= 1'b0;
			nack_q <= 1'b0;
			scl_q <= 1'b1;
			oe_q <= 1'b0;
			ph_q <= 2'h0;
			bit_q <= 4'h0;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (a_wr_q && a_addr_q == `RTS_HA_TXD)
				txd_q <= hwdata[7:0];
			if (qt)
				ph_q <= ph_q + 2'h1;
			unique case (hs_q)
			RTS_H_IDLE: begin
				ph_q <= 2'h0;
				bit_q <= 4'h0;
				// a command written while busy is dropped
				if (a_wr_q && a_addr_q == `RTS_HA_CMD) begin
					op_stop_q <= hwdata[`RTS_OP_STOP];
					op_wr_q <= hwdata[`RTS_OP_WR];
					op_nack_q <= hwdata[`RTS_OP_NACK];
					sh_q <= txd_q;
					if (hwdata[`RTS_OP_START])
						hs_q <= RTS_H_START;
					else if (hwdata[`RTS_OP_WR] || hwdata[`RTS_OP_RD])
						hs_q <= RTS_H_BIT;
					else if (hwdata[`RTS_OP_STOP])
						hs_q <= RTS_H_STOP;
				end
			end
			RTS_H_START: if (qt) begin
				unique case (ph_q)
				2'h0: oe_q <= 1'b0;
				2'h1: scl_q <= 1'b1;
				2'h2: oe_q <= 1'b1;
				2'h3: begin
					scl_q <= 1'b0;
					hs_q <= RTS_H_BIT;
					if (!(a_wr_q || op_wr_q || bit_q != 4'h0) && !op_wr_q && op_stop_q)
						hs_q <= RTS_H_STOP;
				end
				endcase
			end
			RTS_H_BIT: if (qt) begin
				unique case (ph_q)
				2'h0: oe_q <= (bit_q == `RTS_BITS_BYTE) ? (!op_wr_q && !op_nack_q) :
					(op_wr_q && !sh_q[7]);
				2'h1: scl_q <= 1'b1;
				2'h2: begin
					if (bit_q == `RTS_BITS_BYTE)
						nack_q <= op_wr_q && sda_y_q[1];
					else
						sh_q <= {sh_q[6:0], sda_y_q[1]};
				end
				2'h3: begin
					scl_q <= 1'b0;
					bit_q <= bit_q + 4'h1;
					if (bit_q == `RTS_BITS_BYTE) begin
						if (!op_wr_q)
							rxd_q <= sh_q;
						hs_q <= op_stop_q ? RTS_H_STOP : RTS_H_IDLE;
						done_q <= !op_stop_q;
						oe_q <= 1'b0;
					end
				end
				endcase
			end
			RTS_H_STOP: if (qt) begin
				unique case (ph_q)
				2'h0: oe_q <= 1'b1;
				2'h1: scl_q <= 1'b1;
				2'h2: oe_q <= 1'b0;
				2'h3: begin
					hs_q <= RTS_H_IDLE;
					done_q <= 1'b1;
				end
				endcase
			end
			endcase
		end
	end
	assign lnk.scl = scl_q;
	assign lnk.sda_do_h = 1'b0;
	assign lnk.sda_oe_h = oe_q;

	////////////////////////////////////////////////////////////////////////////
	// sticky events; a new event beats a clear in the same cycle
	always_comb begin
		ev = 2'h0;
		ev[`RTS_EV_DONE] = done_q;
		ev[`RTS_EV_PIN] = pin_y_q[1] && !pin_p_q;
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ist_q <= 2'h0;
			ien_q <= 2'h0;
		end else begin
			if (a_wr_q && a_addr_q == `RTS_HA_IRQ_EN)
				ien_q <= hwdata[1:0];
			if (a_wr_q && a_addr_q == `RTS_HA_IRQ_CLR)
				ist_q <= (ist_q & ~hwdata[1:0]) | ev;
			else
				ist_q <= ist_q | ev;
		end
	end
	assign irq = |(ist_q & ien_q);
endmodule // rts_host

// [testbench/rts_checker.sv]
`timescale 1ns/10ps
module rts_checker import rts_pkg::*; (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic scl,
	input wire logic sda_oe_d,
	input wire logic shared_irq_status_pin,
	input wire logic drv_xp,
	input wire logic drv_xn,
	input wire logic drv_yp,
	input wire logic drv_yn,
	input wire logic pen_pullup_en,
	input wire logic pen_touch_n,
	input wire logic adc_start,
	input wire logic [1:0] adc_chan,
	input wire logic adc_lowres,
	input wire logic adc_done,
	input wire logic result_ready_flag,
	input wire logic touch_detect_irq
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	////////////////////////////////
	// pen input is synced, so touch shows a few cycles late
	sequence pen_held;
		(pen_pullup_en && !pen_touch_n) [*3];
	endsequence
	sequence y_conv;
		adc_start && adc_chan == RTS_CH_Y;
	endsequence
	sequence x_conv;
		adc_start && adc_chan == RTS_CH_X;
	endsequence
	dev_sda_hold_a:
	assert property ($changed(sda_oe_d) |-> !scl)
		else $error("device moved sda while scl high");
	y_plate_route_a:
	assert property (y_conv |-> drv_yp && drv_yn && !drv_xp && !drv_xn)
		else $error("wrong plates for y conversion");
	x_plate_route_a:
	assert property (x_conv |-> drv_xp && drv_xn && !drv_yp && !drv_yn)
		else $error("wrong plates for x conversion");
	z_plate_route_a:
	assert property (adc_start && adc_chan[1] |-> drv_yp && drv_xn && !drv_xp && !drv_yn)
		else $error("wrong plates for cross reading");
	coord_full_res_a:
	assert property (adc_start && !adc_chan[1] |-> !adc_lowres)
		else $error("coordinate converted at low resolution");
	ready_after_write_a:
	assert property ($rose(result_ready_flag) |-> $past(adc_done, 2))
		else $error("ready flag not one cycle after result");
	pin_source_a:
	assert property (shared_irq_status_pin |-> result_ready_flag || touch_detect_irq
		|| $past(result_ready_flag) || $past(touch_detect_irq))
		else $error("status pin high without a source");
	idle_ground_a:
	assert property (pen_pullup_en |-> drv_yn && !drv_xp && !drv_xn && !drv_yp)
		else $error("idle plates not in touch watch");
	touch_seen_a:
	assert property (pen_held |-> ##[1:6] touch_detect_irq)
		else $error("touch not flagged");
endmodule // rts_checker

// [testbench/resistive_touch_sequencer_tb.sv]
`timescale 1ns/10ps
`include "rts_cfg.svh"
module resistive_touch_sequencer_tb import rts_pkg::*; ;
	localparam logic [4:0] OS = 5'h01;
	localparam logic [4:0] OP = 5'h02;
	localparam logic [4:0] OW = 5'h04;
	localparam logic [4:0] OR = 5'h08;
	localparam logic [4:0] ON = 5'h10;
	typedef struct packed {
		logic [15:0] cfg;
		logic [2:0] fn;
		logic [11:0] val;
		logic [2:0] rg;
		logic [1:0] ch;
		logic [15:0] ex;
	} rts_row_s;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
	logic [31:0] haddr, hwdata, hrdata, st;
	logic [1:0] htrans, adc_chan, last_ch;
	logic [2:0] hsize;
	logic pen_touch_n, drv_xp, drv_xn, drv_yp, drv_yn, pen_pullup_en, adc_start;
	logic adc_lowres, adc_done, go, last_lr, result_ready_flag, touch_detect_irq;
	logic [11:0] adc_data, adc_val;
	logic [3:0] adc_cnt, drv_last;
	logic [7:0] drv_age, min_age, seq;
	logic [15:0] v;
	int n_mismatch, cmp_count, n_start, cyc, n0;
	rts_row_s rows [5];
	rts_if lnk ();
	rts_host #(.SCL_QTR_CYC(4)) rts_host_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.irq(irq), .lnk(lnk.host));
	rts_dev #(.SETTLE_UNIT_CYC(1)) rts_dev_i (.hclk(hclk), .hresetn(hresetn), .lnk(lnk.dev),
		.pen_touch_n(pen_touch_n), .drv_xp(drv_xp), .drv_xn(drv_xn), .drv_yp(drv_yp),
		.drv_yn(drv_yn), .pen_pullup_en(pen_pullup_en), .adc_start(adc_start),
		.adc_chan(adc_chan), .adc_lowres(adc_lowres), .adc_done(adc_done),
		.adc_data(adc_data), .result_ready_flag(result_ready_flag),
		.touch_detect_irq(touch_detect_irq));
	rts_checker rts_checker_i (.hclk(hclk), .hresetn(hresetn), .scl(lnk.scl),
		.sda_oe_d(lnk.sda_oe_d), .shared_irq_status_pin(lnk.shared_irq_status_pin),
		.drv_xp(drv_xp), .drv_xn(drv_xn), .drv_yp(drv_yp), .drv_yn(drv_yn),
		.pen_pullup_en(pen_pullup_en), .pen_touch_n(pen_touch_n), .adc_start(adc_start),
		.adc_chan(adc_chan), .adc_lowres(adc_lowres), .adc_done(adc_done),
		.result_ready_flag(result_ready_flag), .touch_detect_irq(touch_detect_irq));
	////////////////////////////////
	initial begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_mismatch = n_mismatch + 1;
			final_report();
		end
	end
	// converter stand-in: sample at negedge, answer six cycles after a start
	always @(negedge hclk) begin
		drv_last <= {drv_xp, drv_xn, drv_yp, drv_yn};
		drv_age <= (drv_last != {drv_xp, drv_xn, drv_yp, drv_yn}) ? 8'h00 :
			(drv_age == 8'hFF) ? drv_age : drv_age + 8'h01;
		go <= (adc_cnt == 4'h1);
		if (adc_cnt != 4'h0) adc_cnt <= adc_cnt - 4'h1;
		if (adc_start === 1'b1) begin
			adc_cnt <= 4'h5;
			n_start <= n_start + 1;
			last_ch <= adc_chan;
			last_lr <= adc_lowres;
			seq <= {seq[5:0], adc_chan};
			if (drv_age < min_age) min_age <= drv_age;
		end
	end
	always @(posedge hclk) begin
		adc_done <= go;
		adc_data <= adc_val;
	end
	////////////////////////////////
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count = cmp_count + 1;
		if (seen !== exp) begin
			n_mismatch = n_mismatch + 1;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge hclk);
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h000000, a};
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		st = hrdata;
	endtask
	task lop(input logic [4:0] c, input logic [7:0] b);
		ahb(1'b1, `RTS_HA_TXD, {24'h000000, b});
		ahb(1'b1, `RTS_HA_CMD, {27'h0000000, c});
		st = 32'h00000100;
		while (st[`RTS_ST_BUSY] !== 1'b0) ahb(1'b0, `RTS_HA_STAT, 32'h00000000);
	endtask
	task ctl(input logic [7:0] c);
		lop(OS | OW, 8'h90);
		chk(st[`RTS_ST_NACK], 1'b0);
		lop(OW | OP, c);
	endtask
	task wreg(input logic [2:0] r, input logic [15:0] d);
		lop(OS | OW, 8'h90);
		lop(OW, {2'b00, r, 3'b000});
		lop(OW, d[15:8]);
		lop(OW | OP, d[7:0]);
	endtask
	task rdw(input logic last);
		lop(OR, 8'h00);
		v[15:8] = st[7:0];
		lop(last ? (OR | ON | OP) : OR, 8'h00);
		v[7:0] = st[7:0];
	endtask
	task rd_at(input logic [2:0] r);
		ctl({2'b00, r, 3'b001});
		lop(OS | OW, 8'h91);
	endtask
	task wait_pin();
		st = 32'h00000000;
		while (st[`RTS_ST_PIN] !== 1'b1) ahb(1'b0, `RTS_HA_STAT, 32'h00000000);
	endtask
	task wait_n(input int n);
		while (n_start < n0 + n) ahb(1'b0, `RTS_HA_STAT, 32'h00000000);
	endtask
	task final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	////////////////////////////////
	initial begin
		{hresetn, haddr, htrans, hwrite, hwdata, adc_val, adc_data, adc_done} = '0;
		{go, adc_cnt, drv_age, drv_last, seq, n_mismatch, cmp_count, n_start, cyc} = '0;
		hsel = 1'b1;
		hsize = 3'h2;
		pen_touch_n = 1'b1;
		min_age = 8'hFF;
		rows = '{'{16'h0002, 3'h4, 12'h123, 3'h0, RTS_CH_X, 16'h0123},
			'{16'h0002, 3'h5, 12'hFED, 3'h1, RTS_CH_Y, 16'h0FED},
			'{16'h0002, 3'h6, 12'h800, 3'h2, RTS_CH_Z1, 16'h0800},
			'{16'h0002, 3'h7, 12'h001, 3'h3, RTS_CH_Z2, 16'h0001},
			'{16'h000A, 3'h6, 12'h2AB, 3'h2, RTS_CH_Z1, 16'h0AAC}};
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk({lnk.scl, pen_pullup_en, drv_yn, drv_xp, drv_xn, drv_yp}, 6'h38);
		chk({lnk.shared_irq_status_pin, irq, hresp}, 3'h0);
		$display("reset test done");
		foreach (rows[i]) begin
			wreg(`RTS_REG_CFG, rows[i].cfg);
			adc_val = rows[i].val;
			ctl({1'b1, rows[i].fn, 4'h0});
			wait_pin();
			chk(last_ch, rows[i].ch);
			chk(last_lr, rows[i].cfg[3]);
			rd_at(rows[i].rg);
			rdw(1'b1);
			chk(v, rows[i].ex);
			ahb(1'b0, `RTS_HA_STAT, 32'h00000000);
			chk(st[`RTS_ST_PIN], 1'b0);
			$display("row %0d done", i);
		end
		// pointer at the last register wraps to the first, and persists
		pen_touch_n <= 1'b0;
		rd_at(`RTS_REG_STAT);
		for (int k = 0; k < 2; k++) begin
			if (k == 1) lop(OS | OW, 8'h91);
			rdw(1'b0);
			chk(v, 16'h4000);
			rdw(1'b1);
			chk(v, 16'h0123);
		end
		pen_touch_n <= 1'b1;
		$display("pointer test done");
		n0 = n_start;
		ctl(8'hA0);
		chk({drv_xp, drv_xn, drv_yp, drv_yn}, 4'h3);
		ctl(8'hB0);
		chk({drv_xp, drv_xn, drv_yp, drv_yn}, 4'h6);
		ctl(8'h90);
		repeat (20) ahb(1'b0, `RTS_HA_STAT, 32'h00000000);
		chk({drv_xp, drv_xn, drv_yp, drv_yn}, 4'hC);
		chk(n_start - n0, 0);
		ctl(8'hC0);
		wait_pin();
		chk(n_start - n0, 1);
		$display("drive only test done");
		wreg(`RTS_REG_CFG, 16'h0301);
		min_age = 8'hFF;
		n0 = n_start;
		ctl(8'h80);
		wait_n(4);
		chk(seq, 8'h1B);
		chk(min_age >= 8'h03, 1'b1);
		$display("scan test done");
		wreg(`RTS_REG_CFG, 16'h0104);
		ahb(1'b1, `RTS_HA_IRQ_CLR, 32'h00000003);
		ahb(1'b1, `RTS_HA_IRQ_EN, 32'h00000002);
		n0 = n_start;
		pen_touch_n <= 1'b0;
		wait_n(4);
		chk(irq, 1'b1);
		ahb(1'b1, `RTS_HA_IRQ_EN, 32'h00000000);
		// enable lands at the data-phase edge; look one edge later
		@(posedge hclk);
		chk(irq, 1'b0);
		pen_touch_n <= 1'b1;
		repeat (30) ahb(1'b0, `RTS_HA_STAT, 32'h00000000);
		ahb(1'b1, `RTS_HA_IRQ_CLR, 32'h00000002);
		ahb(1'b0, `RTS_HA_IRQ_ST, 32'h00000000);
		chk(st[`RTS_EV_PIN], 1'b0);
		$display("touch test done");
		// software reset drops pointer and results; pointer parked on config first
		ctl(8'h21);
		ctl(8'h88);
		wreg(`RTS_REG_CFG, 16'h0002);
		lop(OS | OW, 8'h91);
		rdw(1'b1);
		chk(v, 16'h0000);
		lop(OS | OW, 8'hA0);
		chk(st[`RTS_ST_NACK], 1'b1);
		lop(OP, 8'h00);
		$display("reset and address test done");
		final_report();
	end
endmodule // resistive_touch_sequencer_tb
